// [core/bpt_pkg.sv]
// Constants and types for the bank close timing block
package bpt_pkg;
  localparam int unsigned BankCount      = 8;
  localparam int unsigned BankBits       = 3;
  localparam int unsigned CntBits        = 6;
  localparam int unsigned ClkPeriodPs    = 20000;
  // Analog minimums in picoseconds
  localparam int unsigned RowOpenMinPs   = 45000;
  localparam int unsigned ReadCloseMinPs = 7500;
  localparam int unsigned RowCloseMinPs  = 15000;
  localparam int unsigned RowCycleMinPs  = 60000;
  // Least times round up to whole cycles
  localparam logic [5:0] RowOpenCyc   = 6'((RowOpenMinPs + ClkPeriodPs - 1) / ClkPeriodPs);
  localparam logic [5:0] ReadCloseCyc = 6'((ReadCloseMinPs + ClkPeriodPs - 1) / ClkPeriodPs);
  localparam logic [5:0] RowCloseCyc  = 6'((RowCloseMinPs + ClkPeriodPs - 1) / ClkPeriodPs);
  localparam logic [5:0] RowCycleCyc  = 6'((RowCycleMinPs + ClkPeriodPs - 1) / ClkPeriodPs);
  localparam logic [5:0] PrefetchGap  = 6'h02;
  localparam logic [5:0] Burst8Extra  = 6'h02;
  localparam logic [5:0] OneCyc       = 6'h01;
  localparam logic [5:0] ZeroCyc      = 6'h00;
  // Command codes
  typedef enum logic [2:0] {
    CMD_NOP   = 3'h0,
    CMD_OPEN  = 3'h1,
    CMD_READ  = 3'h2,
    CMD_WRITE = 3'h3,
    CMD_CLOSE = 3'h4
  } bpt_cmd_type;
  // Per-bank state, Gray along idle-open-closing
  typedef enum logic [1:0] {
    BK_IDLE    = 2'h0,
    BK_OPEN    = 2'h1,
    BK_CLOSING = 2'h3
  } bpt_bank_type;
endpackage : bpt_pkg

// [core/bpt_bank_timer.sv]
// One bank: state and minimum-time counters
`timescale 1ns/1ps
`default_nettype none
module bpt_bank_timer (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Events for this bank
  input  wire logic       openEv,
  input  wire logic       closeEv,
  input  wire logic       readAcEv,
  input  wire logic       writeAcEv,
  input  wire logic [5:0] readCloseDelay,
  input  wire logic [5:0] writeCloseDelay,
  // Status
  output logic            bankOpen,
  output logic            bankClosing,
  output logic            closeStart
);
  // ==========================================================
  // State
  typedef struct packed {
    bpt_pkg::bpt_bank_type st;
    logic [5:0] openCnt;
    logic [5:0] acCnt;
    logic [5:0] rtpCnt;
    logic [5:0] rpCnt;
    logic       acPend;
    logic       start;
  } bpt_bank_state_type;
  bpt_bank_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    if (s_q.openCnt != bpt_pkg::ZeroCyc) s_d.openCnt = s_q.openCnt - bpt_pkg::OneCyc;
    if (s_q.acCnt != bpt_pkg::ZeroCyc) s_d.acCnt = s_q.acCnt - bpt_pkg::OneCyc;
    if (s_q.rtpCnt != bpt_pkg::ZeroCyc) s_d.rtpCnt = s_q.rtpCnt - bpt_pkg::OneCyc;
    if (s_q.rpCnt != bpt_pkg::ZeroCyc) s_d.rpCnt = s_q.rpCnt - bpt_pkg::OneCyc;
    unique case (s_q.st)
      bpt_pkg::BK_IDLE: begin
        if (openEv) begin
          s_d.st = bpt_pkg::BK_OPEN;
          s_d.openCnt = bpt_pkg::RowOpenCyc;
        end
      end
      bpt_pkg::BK_OPEN: begin
        if (closeEv) begin // RL1
          s_d.st = bpt_pkg::BK_CLOSING;
          s_d.rpCnt = bpt_pkg::RowCloseCyc;
          s_d.acPend = 1'b0;
          s_d.start = 1'b1;
        end else if (readAcEv && !s_q.acPend) begin // RL7
          s_d.acPend = 1'b1;
          s_d.acCnt = readCloseDelay; // RL9 RL12
          s_d.rtpCnt = readCloseDelay + bpt_pkg::ReadCloseCyc - bpt_pkg::PrefetchGap; // RL5
        end else if (writeAcEv && !s_q.acPend) begin // RL7
          s_d.acPend = 1'b1;
          s_d.acCnt = writeCloseDelay; // RL14
          s_d.rtpCnt = bpt_pkg::ZeroCyc;
        end else if (s_q.acPend && s_q.acCnt <= bpt_pkg::OneCyc && s_q.openCnt <= bpt_pkg::OneCyc
                     && s_q.rtpCnt <= bpt_pkg::OneCyc) begin // RL8 RL10 RL16
          s_d.st = bpt_pkg::BK_CLOSING;
          s_d.rpCnt = bpt_pkg::RowCloseCyc; // RL11
          s_d.acPend = 1'b0;
          s_d.start = 1'b1;
        end
      end
      bpt_pkg::BK_CLOSING: begin
        if (s_q.rpCnt <= bpt_pkg::OneCyc) s_d.st = bpt_pkg::BK_IDLE;
      end
      default: s_d.st = bpt_pkg::BK_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // RL21
  assign bankOpen    = (s_q.st == bpt_pkg::BK_OPEN);
  assign bankClosing = (s_q.st == bpt_pkg::BK_CLOSING);
  assign closeStart  = s_q.start;
endmodule : bpt_bank_timer // bpt_bank_timer
`default_nettype wire

// [core/bpt_bank_precharge_timing.sv]
// Bank close decode, auto-close and per-bank timing for eight banks
// How it works
// RL1 - Close all when bit high, else one
// RL2 - Controller spaces read to close correctly
// RL3 - Controller respects row-open minimum before close
// RL4 - Controller waits row close before reopen
// RL5 - Read-to-close measured from internal read point
// RL6 - Controller spaces write to close correctly
// RL7 - Sample auto-close bit on read/write
// RL8 - Read auto-close starts CL before burst end
// RL9 - Nominal start additive plus half burst
// RL10 - Postpone close until minimums are met
// RL11 - Row close follows read-to-close end
// RL12 - Never earlier than two after last prefetch
// RL13 - Controller reopens after close and cycle time
// RL14 - Write auto-close after burst plus recovery
// RL15 - Controller reopens after recovery plus close
// RL16 - Auto-close held until row-open minimum met
// RL17 - Closes may follow each other after 1
// RL18 - Read delay additive plus CL; write one less
// RL19 - Burst count only 4 or 8
// RL20 - Read-to-close cycles round up
// RL21 - Per-bank state and counters
`timescale 1ns/1ps
`default_nettype none
module bpt_bank_precharge_timing (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Command from decode
  input  wire logic [2:0] cmd,
  input  wire logic       autoCloseAddressBit,
  input  wire logic       bankSelectBit0,
  input  wire logic       bankSelectBit1,
  input  wire logic       bankSelectBit2,
  // Latency settings
  input  wire logic [2:0] additiveDelay,
  input  wire logic [2:0] columnAccessLatency,
  input  wire logic       burstCountIs8,
  input  wire logic [2:0] writeRecoveryTime,
  // Bank status
  output logic [7:0]      bankOpen,
  output logic [7:0]      bankClosing,
  output logic [7:0]      closeStart,
  output logic [3:0]      readDelay,
  output logic [3:0]      writeDelay
);
  // ==========================================================
  // Decode
  function automatic logic [7:0] bankMask(input logic [2:0] b);
    bankMask = 8'h01 << b;
  endfunction

  logic [2:0] bankSel;
  logic [7:0] selMask;
  logic [5:0] halfBurst;
  logic [5:0] rdClose;
  logic [5:0] wrClose;
  logic [7:0] openOut;
  logic [7:0] closingOut;
  logic [7:0] startOut;

  typedef struct packed {
    logic [3:0] rl;
    logic [3:0] wl;
    logic [7:0] open;
    logic [7:0] closing;
    logic [7:0] start;
  } bpt_top_state_type;
  bpt_top_state_type s_q, s_d;

  assign bankSel = {bankSelectBit2, bankSelectBit1, bankSelectBit0};
  assign selMask = bankMask(bankSel);
  assign halfBurst = burstCountIs8 ? 6'h04 : 6'h02; // RL19
  // Nominal read auto-close edge, at least 2 after last prefetch
  assign rdClose = 6'(additiveDelay) + halfBurst; // RL9 RL12
  // Write: delay + half burst + recovery, from the command
  assign wrClose = 6'(additiveDelay) + 6'(columnAccessLatency) - bpt_pkg::OneCyc
                   + halfBurst + 6'(writeRecoveryTime); // RL14 RL18

  // ==========================================================
  // Banks
  genvar g;
  generate
    for (g = 0; g < bpt_pkg::BankCount; g++) begin : gBank
      logic hit;
      assign hit = selMask[g];
      bpt_bank_timer uBank (
        .clk            (clk),
        .rstn           (rstn),
        .openEv         (cmd == bpt_pkg::CMD_OPEN && hit),
        .closeEv        (cmd == bpt_pkg::CMD_CLOSE && (autoCloseAddressBit || hit)), // RL1
        .readAcEv       (cmd == bpt_pkg::CMD_READ && hit && autoCloseAddressBit),
        .writeAcEv      (cmd == bpt_pkg::CMD_WRITE && hit && autoCloseAddressBit),
        .readCloseDelay (rdClose),
        .writeCloseDelay(wrClose),
        .bankOpen       (openOut[g]),
        .bankClosing    (closingOut[g]),
        .closeStart     (startOut[g])
      );
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.rl = 4'(additiveDelay) + 4'(columnAccessLatency); // RL18
    s_d.wl = 4'(additiveDelay) + 4'(columnAccessLatency) - 4'h1; // RL18
    s_d.open = openOut;
    s_d.closing = closingOut;
    s_d.start = startOut;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bankOpen    = s_q.open;
  assign bankClosing = s_q.closing;
  assign closeStart  = s_q.start;
  assign readDelay   = s_q.rl;
  assign writeDelay  = s_q.wl;
endmodule : bpt_bank_precharge_timing // bpt_bank_precharge_timing
`default_nettype wire

// [verification/bpt_props.sv]
// Port-level checks of the bank close block
`timescale 1ns/1ps
`default_nettype none
module bpt_props (
  input wire logic       clk, rstn, autoCloseAddressBit,
  input wire logic       bankSelectBit0, bankSelectBit1, bankSelectBit2,
  input wire logic [2:0] cmd, additiveDelay, columnAccessLatency,
  input wire logic [7:0] bankOpen, bankClosing, closeStart,
  input wire logic [3:0] readDelay, writeDelay
);
  // ====
  // Properties
  logic [2:0] sel;
  assign sel = {bankSelectBit2, bankSelectBit1, bankSelectBit0};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  rd_sum_a: assert property ($past(rstn, 3) |-> readDelay == 4'($past(additiveDelay)) + 4'($past(columnAccessLatency)))
    else $error("read delay wrong");
  wr_less_a: assert property ($past(rstn, 3) |-> writeDelay == readDelay - 4'h1)
    else $error("write delay wrong");
  open_one_a: assert property (cmd == bpt_pkg::CMD_OPEN && !bankOpen[sel] && !bankClosing[sel]
    |-> ##2 bankOpen[$past(sel, 2)]) else $error("open lost");
  close_one_a: assert property (cmd == bpt_pkg::CMD_CLOSE && !autoCloseAddressBit && bankOpen[sel]
    |-> ##2 closeStart == 8'h01 << $past(sel, 2)) else $error("single close wrong");
  close_all_a: assert property (cmd == bpt_pkg::CMD_CLOSE && autoCloseAddressBit
    |-> ##2 bankOpen == 8'h00 && closeStart == $past(bankOpen)) else $error("close all wrong");
  // Row-open minimum is three cycles at this clock
  open_min_a: assert property ((closeStart & ~$past(bankOpen, 3)) == 8'h00)
    else $error("close too early");
  closing_len_a: assert property ((bankClosing & $past(bankClosing)) == 8'h00)
    else $error("closing too long");
  closing_excl_a: assert property ((bankClosing & bankOpen) == 8'h00)
    else $error("open while closing");
  cover property (cmd == bpt_pkg::CMD_CLOSE && autoCloseAddressBit);
  cover property (cmd == bpt_pkg::CMD_READ && autoCloseAddressBit);
  cover property (cmd == bpt_pkg::CMD_WRITE && autoCloseAddressBit);
endmodule // bpt_props
`default_nettype wire

// [verification/bpt_ctrl_model.sv]
// Command driver standing in for the memory controller
`timescale 1ns/1ps
`default_nettype none
module bpt_ctrl_model (
  input  wire logic       clk, go, autoIn,
  input  wire logic [2:0] opIn, bankIn,
  output logic [2:0]      cmd, bank,
  output logic            autoBit
);
  // ====
  // Drive
  logic [6:0] drive_q = 7'h00;
  // Address lines flip while idle so a decode that ignores the command shows up
  always @(posedge clk) begin
    drive_q <= go ? {opIn, bankIn, autoIn} : {3'h0, ~drive_q[3:0]};
  end
  assign {cmd, bank, autoBit} = drive_q;
endmodule // bpt_ctrl_model
`default_nettype wire

// [verification/tb_bpt_bank_precharge_timing.sv]
// Self-checking bench of the bank close block
`timescale 1ns/1ps
`default_nettype none
module tb_bpt_bank_precharge_timing;
  // ====
  // Signals
  logic       clk = 1'b0, rstn = 1'b0, go = 1'b0, autoIn = 1'b0, isBl8 = 1'b0, autoBit;
  logic [2:0] opIn = 3'h0, bankIn = 3'h0, wrRec = 3'h3, addDel = 3'h2, casLat = 3'h3, cmd, bank;
  logic [7:0] bankOpen, bankClosing, closeStart;
  logic [3:0] readDelay, writeDelay;
  int         failures = 0, checks_done = 0, cyc = 0;
  always #10 clk = ~clk;
  bpt_ctrl_model ctrl_u (.clk, .go, .autoIn, .opIn, .bankIn, .cmd, .bank, .autoBit);
  bpt_bank_precharge_timing dut_u (.clk, .rstn, .cmd, .autoCloseAddressBit(autoBit),
    .bankSelectBit0(bank[0]), .bankSelectBit1(bank[1]), .bankSelectBit2(bank[2]),
    .additiveDelay(addDel), .columnAccessLatency(casLat), .burstCountIs8(isBl8),
    .writeRecoveryTime(wrRec), .bankOpen, .bankClosing, .closeStart, .readDelay, .writeDelay);
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [2:0] op, b, input logic a);
    @(posedge clk);
    go <= 1'b1;
    {opIn, bankIn, autoIn} <= {op, b, a};
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Counts cycles from the end of issue until the bank reports its close start
  task automatic closeWait(input logic [2:0] b, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    while (closeStart[b] !== 1'b1 && n < 8'h28) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, exp);
  endtask
  task automatic t_single;
    for (int b = 0; b < 8; b++) begin
      issue(bpt_pkg::CMD_OPEN, 3'(b), 1'b0);
      repeat (6) @(posedge clk);
      issue(bpt_pkg::CMD_CLOSE, 3'(b), 1'b0);
      closeWait(3'(b), 8'h02);
      chk(closeStart, 8'h01 << b);
      chk(bankClosing, 8'h01 << b);
    end
    issue(bpt_pkg::CMD_OPEN, 3'h3, 1'b0);
    issue(bpt_pkg::CMD_OPEN, 3'h6, 1'b0);
    repeat (6) @(posedge clk);
    issue(bpt_pkg::CMD_CLOSE, 3'h0, 1'b1);
    closeWait(3'h6, 8'h02);
    chk(closeStart, 8'h48);
    chk(bankClosing, 8'h48);
    $display("close decode test done");
  endtask
  task automatic t_auto;
    int al, cl, bl, wr;
    for (int m = 0; m < 2; m++) begin
      al = 2 - 2 * m;
      cl = 3 + m;
      bl = 4 + 4 * m;
      wr = 3 + 2 * m;
      @(posedge clk);
      {isBl8, wrRec, addDel, casLat} <= {1'(m), 3'(wr), 3'(al), 3'(cl)};
      issue(bpt_pkg::CMD_OPEN, 3'h4, 1'b0);
      #1 chk(8'(readDelay), 8'(al + cl));
      chk(8'(writeDelay), 8'(al + cl - 1));
      repeat (6) @(posedge clk);
      issue(bpt_pkg::CMD_READ, 3'h4, 1'b1);
      // Two extra cycles: bank state register sampling the command, output register here
      closeWait(3'h4, 8'(al + bl / 2 + 2));
      repeat (4) @(posedge clk);
      issue(bpt_pkg::CMD_OPEN, 3'h4, 1'b0);
      repeat (6) @(posedge clk);
      issue(bpt_pkg::CMD_WRITE, 3'h4, 1'b1);
      closeWait(3'h4, 8'(al + cl - 1 + bl / 2 + wr + 2));
      repeat (4) @(posedge clk);
    end
    issue(bpt_pkg::CMD_OPEN, 3'h5, 1'b0);
    issue(bpt_pkg::CMD_READ, 3'h5, 1'b0);
    repeat (20) @(posedge clk);
    #1 chk(bankOpen, 8'h20);
    issue(bpt_pkg::CMD_CLOSE, 3'h5, 1'b0);
    closeWait(3'h5, 8'h02);
    chk(bankOpen, 8'h00);
    $display("auto close test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk(8'(readDelay), 8'h05);
    chk(8'(writeDelay), 8'h04);
    t_single();
    t_auto();
    results();
  end
endmodule // tb_bpt_bank_precharge_timing
bind bpt_bank_precharge_timing bpt_props props_u (.clk, .rstn, .cmd, .autoCloseAddressBit, .bankSelectBit0,
  .bankSelectBit1, .bankSelectBit2, .additiveDelay, .columnAccessLatency, .bankOpen, .bankClosing,
  .closeStart, .readDelay, .writeDelay);
`default_nettype wire
